/* logic/nvc_pkg.sv */
// shared constants and types for the nvsram host controller
package nvc_pkg;
   localparam int NVC_ADDR_W = 15;
   localparam int NVC_DATA_W = 8;
   localparam int NVC_SEQ_LEN = 6;
   localparam logic [13:0] NVC_SEQ_0 = 14'h0E38;
   localparam logic [13:0] NVC_SEQ_1 = 14'h31C7;
   localparam logic [13:0] NVC_SEQ_2 = 14'h03E0;
   localparam logic [13:0] NVC_SEQ_3 = 14'h3C1F;
   localparam logic [13:0] NVC_SEQ_4 = 14'h303F;
   localparam logic [13:0] NVC_SEQ_STORE = 14'h0FC0;
   localparam logic [13:0] NVC_SEQ_RECALL = 14'h0C63;
   localparam logic NVC_ADDR_MSB_DEFAULT = 1'h0;
   localparam int NVC_CLK_MHZ = 40;
   localparam int NVC_STORE_MS = 10;
   localparam int NVC_RECALL_US = 20;
   localparam int NVC_POWERUP_RECALL_US = 550;
   localparam int NVC_STORE_CYC = NVC_STORE_MS * 1000 * NVC_CLK_MHZ;
   localparam int NVC_RECALL_CYC = NVC_RECALL_US * NVC_CLK_MHZ;
   localparam int NVC_POWERUP_CYC = NVC_POWERUP_RECALL_US * NVC_CLK_MHZ;
   localparam int NVC_SETUP_CYC = 1;
   localparam int NVC_STROBE_CYC = 2;
   localparam int NVC_HOLD_CYC = 1;
   localparam int NVC_CNT_W = 24;

   typedef enum logic [1:0] {NVC_OP_READ, NVC_OP_WRITE, NVC_OP_STORE, NVC_OP_RECALL} nvc_op_t;

   typedef struct packed {
      nvc_op_t op;
      logic [NVC_ADDR_W-1:0] addr;
      logic [NVC_DATA_W-1:0] data;
   } nvc_req_t;

   typedef struct packed {
      logic chipSelN;
      logic writeN;
      logic outEnN;
      logic [NVC_ADDR_W-1:0] addressLines;
      logic [NVC_DATA_W-1:0] byteLinesOut;
      logic byteLinesOeN;
   } nvc_pins_t;
endpackage : nvc_pkg

/* logic/nvc_wait_timer.sv */
// down counter that holds the controller off for a set number of cycles
`timescale 1ns/1ps
module nvc_wait_timer
   import nvc_pkg::*;
#(
   parameter int CNT_W = NVC_CNT_W
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic [CNT_W-1:0] loadValue,
   output logic busy
);
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;

   initial
   begin
      if (CNT_W < 2)
      begin
         $error("nvc_wait_timer: counter too narrow");
      end
   end

   always_comb
   begin
      next_count = count;
      if (load)
      begin
         next_count = loadValue;
      end
      else if (count != '0)
      begin
         next_count = count - CNT_W'(1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         count <= '0;
      end
      else
      begin
         count <= next_count;
      end
   end

   assign busy = (count != '0);
endmodule : nvc_wait_timer

/* logic/nvc_host_ctrl.sv */
// host side controller: drives sram cycles and store/recall sequences
// Overview of operation
// - read has write high, write has low
// - address changes only while deselected
// - store: five keys then 0FC0
// - recall: five keys then 0C63
// - all six sequence cycles are reads
// - one chip-select pulse per sequence address
// - no other access inside a sequence
`timescale 1ns/1ps
module nvc_host_ctrl
   import nvc_pkg::*;
#(
   parameter int STORE_CYC = NVC_STORE_CYC,
   parameter int RECALL_CYC = NVC_RECALL_CYC,
   parameter int POWERUP_CYC = NVC_POWERUP_CYC
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic reqValid,
   input wire nvc_req_t req,
   output logic reqReady,
   output logic [NVC_DATA_W-1:0] rdData,
   output logic rdValid,
   output logic opDone,
   output nvc_pins_t pins,
   input wire logic [NVC_DATA_W-1:0] byteLinesIn
);
   typedef enum {S_POWERUP, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_WAIT} nvc_state_t;

   nvc_state_t state, next_state;
   nvc_req_t cur, next_cur;
   logic [2:0] step, next_step;
   logic [3:0] phase, next_phase;
   nvc_pins_t next_pins;
   logic [NVC_DATA_W-1:0] next_rdData;
   logic next_rdValid, next_opDone, next_reqReady;
   logic [NVC_DATA_W-1:0] dqMeta, dqSync;
   logic tLoad;
   logic [NVC_CNT_W-1:0] tValue;
   logic tBusy;
   logic seqOp;
   logic [13:0] seqAddr;

   initial
   begin
      if (STORE_CYC < 1 || STORE_CYC >= (1 << NVC_CNT_W) || RECALL_CYC < 1 || POWERUP_CYC < 1)
      begin
         $error("nvc_host_ctrl: wait counts out of range");
      end
   end

   nvc_wait_timer #(.CNT_W(NVC_CNT_W)) u_timer (
      .clock(clock),
      .rst(rst),
      .load(tLoad),
      .loadValue(tValue),
      .busy(tBusy)
   );

   // byte lines come from off chip
   always_ff @(posedge clock)
   begin
      dqMeta <= byteLinesIn;
      dqSync <= dqMeta;
   end

   assign seqOp = (cur.op == NVC_OP_STORE) || (cur.op == NVC_OP_RECALL);

   always_comb
   begin
      case (step)
         3'h0: seqAddr = NVC_SEQ_0;
         3'h1: seqAddr = NVC_SEQ_1;
         3'h2: seqAddr = NVC_SEQ_2;
         3'h3: seqAddr = NVC_SEQ_3;
         3'h4: seqAddr = NVC_SEQ_4;
         default: seqAddr = (cur.op == NVC_OP_STORE) ? NVC_SEQ_STORE : NVC_SEQ_RECALL;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_cur = cur;
      next_step = step;
      next_phase = phase;
      next_pins = pins;
      next_rdData = rdData;
      next_rdValid = 1'b0;
      next_opDone = 1'b0;
      next_reqReady = 1'b0;
      tLoad = 1'b0;
      tValue = '0;
      case (state)
         S_POWERUP:
         begin
            if (!tBusy && phase != 4'h0)
            begin
               next_state = S_IDLE;
               next_reqReady = 1'b1;
            end
            next_phase = 4'h1;
         end
         S_IDLE:
         begin
            next_reqReady = 1'b1;
            if (reqValid)
            begin
               next_cur = req;
               next_step = 3'h0;
               next_reqReady = 1'b0;
               next_state = S_SETUP;
            end
         end
         S_SETUP:
         begin
            next_pins.chipSelN = 1'b1;
            next_pins.outEnN = 1'b1;
            if (seqOp)
            begin
               // top address bit is don't care
               next_pins.addressLines = {NVC_ADDR_MSB_DEFAULT, seqAddr};
            end
            else
            begin
               next_pins.addressLines = cur.addr;
            end
            next_pins.writeN = (cur.op != NVC_OP_WRITE);
            next_pins.byteLinesOut = cur.data;
            next_pins.byteLinesOeN = (cur.op != NVC_OP_WRITE);
            next_phase = 4'h0;
            next_state = S_STROBE;
         end
         S_STROBE:
         begin
            next_pins.chipSelN = 1'b0;
            next_pins.outEnN = (cur.op == NVC_OP_WRITE);
            next_phase = phase + 4'h1;
            if (phase == 4'(NVC_STROBE_CYC - 1))
            begin
               next_state = S_HOLD;
               next_phase = 4'h0;
            end
         end
         S_HOLD:
         begin
            next_pins.chipSelN = 1'b1;
            next_pins.outEnN = 1'b1;
            next_pins.writeN = 1'b1;
            next_pins.byteLinesOeN = 1'b1;
            // extra hold cycle lets read data clear the synchroniser
            if (cur.op == NVC_OP_READ && phase == 4'(NVC_HOLD_CYC))
            begin
               next_rdData = dqSync;
               next_rdValid = 1'b1;
            end
            if (phase != 4'(NVC_HOLD_CYC))
            begin
               next_phase = phase + 4'h1;
            end
            else if (seqOp && step != 3'(NVC_SEQ_LEN - 1))
            begin
               next_step = step + 3'h1;
               next_state = S_SETUP;
            end
            else if (cur.op == NVC_OP_STORE)
            begin
               tLoad = 1'b1;
               tValue = NVC_CNT_W'(STORE_CYC);
               next_state = S_WAIT;
            end
            else if (cur.op == NVC_OP_RECALL)
            begin
               tLoad = 1'b1;
               tValue = NVC_CNT_W'(RECALL_CYC);
               next_state = S_WAIT;
            end
            else
            begin
               next_opDone = 1'b1;
               next_reqReady = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_WAIT:
         begin
            if (!tBusy && !tLoad)
            begin
               next_opDone = 1'b1;
               next_reqReady = 1'b1;
               next_state = S_IDLE;
            end
         end
         default:
         begin
            next_state = S_IDLE;
         end
      endcase
      if (state == S_POWERUP && phase == 4'h0)
      begin
         tLoad = 1'b1;
         tValue = NVC_CNT_W'(POWERUP_CYC);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state <= S_POWERUP;
         cur <= '0;
         step <= 3'h0;
         phase <= 4'h0;
         pins <= '{chipSelN: 1'b1, writeN: 1'b1, outEnN: 1'b1, addressLines: '0, byteLinesOut: '0, byteLinesOeN: 1'b1};
         rdData <= '0;
         rdValid <= 1'b0;
         opDone <= 1'b0;
         reqReady <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cur <= next_cur;
         step <= next_step;
         phase <= next_phase;
         pins <= next_pins;
         rdData <= next_rdData;
         rdValid <= next_rdValid;
         opDone <= next_opDone;
         reqReady <= next_reqReady;
      end
   end

   addr_stable_a: assert property (@(posedge clock) disable iff (rst)
      !pins.chipSelN && !$past(pins.chipSelN) |-> $stable(pins.addressLines))
      else $error("address moved during select");
   seq_no_write_a: assert property (@(posedge clock) disable iff (rst)
      seqOp && state != S_IDLE |-> pins.writeN)
      else $error("write during sequence");
   no_contention_a: assert property (@(posedge clock) disable iff (rst)
      !(!pins.byteLinesOeN && !pins.outEnN))
      else $error("bus contention");
   we_before_cs_a: assert property (@(posedge clock) disable iff (rst)
      $fell(pins.chipSelN) |-> $stable(pins.writeN))
      else $error("write strobe changed at select");
   wait_idle_a: assert property (@(posedge clock) disable iff (rst)
      state == S_WAIT |-> pins.chipSelN && pins.byteLinesOeN)
      else $error("access during transfer");
   cs_width_a: assert property (@(posedge clock) disable iff (rst)
      $fell(pins.chipSelN) |-> !pins.chipSelN [*2] ##1 pins.chipSelN)
      else $error("select pulse width wrong");
   seq_msb_a: assert property (@(posedge clock) disable iff (rst)
      seqOp && !pins.chipSelN |-> pins.addressLines[14] == NVC_ADDR_MSB_DEFAULT)
      else $error("sequence msb changed");
   store_key_a: assert property (@(posedge clock) disable iff (rst)
      cur.op == NVC_OP_STORE && step == 3'h5 && !pins.chipSelN |-> pins.addressLines[13:0] == NVC_SEQ_STORE)
      else $error("bad store key");
   recall_key_a: assert property (@(posedge clock) disable iff (rst)
      cur.op == NVC_OP_RECALL && step == 3'h5 && !pins.chipSelN |-> pins.addressLines[13:0] == NVC_SEQ_RECALL)
      else $error("bad recall key");

   cov_read_c: cover property (@(posedge clock) rdValid);
   cov_store_c: cover property (@(posedge clock) opDone && cur.op == NVC_OP_STORE);
   cov_recall_c: cover property (@(posedge clock) opDone && cur.op == NVC_OP_RECALL);
   cov_write_c: cover property (@(posedge clock) !pins.writeN && !pins.chipSelN);
endmodule : nvc_host_ctrl

/* test/nvc_dev_model.sv */
// behavioural model of the shadowed sram seen through its pins
`timescale 1ns/1ps
module nvc_dev_model
   import nvc_pkg::*;
#(
   parameter int STORE_BUSY = 40,
   parameter int RECALL_BUSY = 15,
   parameter int POWER_BUSY = 25
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic lowSupply,
   input wire nvc_pins_t pins,
   output logic [NVC_DATA_W-1:0] lineLevel,
   output int storeCount,
   output int recallCount,
   output int selCount,
   output int violations
);
   logic [7:0] sram [0:32767];
   logic [7:0] shadow [0:32767];
   logic [7:0] last;
   logic selD;
   logic writeAtSel;
   logic [14:0] addrD;
   int busy;
   int step;
   logic drive;
   function automatic logic [13:0] keyAt(input int s);
      case (s)
         0: keyAt = NVC_SEQ_0;
         1: keyAt = NVC_SEQ_1;
         2: keyAt = NVC_SEQ_2;
         3: keyAt = NVC_SEQ_3;
         default: keyAt = NVC_SEQ_4;
      endcase
   endfunction : keyAt
   // drive only on reads not begun as writes, never while busy
   assign drive = !pins.chipSelN && pins.writeN && !pins.outEnN && busy == 0 && !(selD ? 1'b0 : writeAtSel);
   // undriven lines show the inverse of the last level, not a stale copy
   assign lineLevel = !pins.byteLinesOeN ? pins.byteLinesOut : drive ? sram[pins.addressLines] : ~last;
   always @(posedge clock)
   begin
      last <= lineLevel;
      selD <= pins.chipSelN;
      addrD <= pins.addressLines;
      if (rst)
      begin
         // power-up recall holds the part off
         busy <= POWER_BUSY;
         step <= 0;
         storeCount <= 0;
         recallCount <= 0;
         selCount <= 0;
         violations <= 0;
         writeAtSel <= 1'b0;
      end
      else if (busy > 0)
      begin
         busy <= busy - 1;
         // a new select during a transfer is a host fault
         if (selD && !pins.chipSelN)
            violations <= violations + 1;
      end
      else
      begin
         // address must not move while selected
         if (!pins.chipSelN && !selD && pins.addressLines != addrD)
            violations <= violations + 1;
         if (!pins.chipSelN && !pins.writeN)
            sram[pins.addressLines] <= pins.byteLinesOut;
         if (selD && !pins.chipSelN)
         begin
            selCount <= selCount + 1;
            writeAtSel <= !pins.writeN;
            // writes or strays abort, first key restarts
            if (!pins.writeN)
               step <= 0;
            // low 14 bits only, fixed order
            else if (step < 5 && pins.addressLines[13:0] == keyAt(step))
               step <= step + 1;
            else if (step == 5 && pins.addressLines[13:0] == NVC_SEQ_STORE && !lowSupply)
            begin
               step <= 0;
               busy <= STORE_BUSY;
               storeCount <= storeCount + 1;
               for (int i = 0; i < 32768; i++)
                  shadow[i] <= sram[i];
            end
            else if (step == 5 && pins.addressLines[13:0] == NVC_SEQ_RECALL)
            begin
               step <= 0;
               busy <= RECALL_BUSY;
               recallCount <= recallCount + 1;
               for (int i = 0; i < 32768; i++)
                  sram[i] <= shadow[i];
            end
            else
               step <= (pins.addressLines[13:0] == NVC_SEQ_0) ? 1 : 0;
         end
      end
   end
endmodule : nvc_dev_model

/* test/tb.sv */
// testbench for the nvsram host controller
`timescale 1ns/1ps
module tb;
   import nvc_pkg::*;
   localparam int ST = 50;
   localparam int RC = 20;
   localparam int PU = 30;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   logic lowSupply = 1'b0;
   nvc_req_t req = '0;
   logic reqReady;
   logic [7:0] rdData;
   logic rdValid;
   logic opDone;
   nvc_pins_t pins;
   logic [7:0] lineLevel;
   int storeCount, recallCount, selCount, violations;
   int fails = 0;
   int check_count = 0;
   int cyc;
   always #12.5 clock = ~clock;
   nvc_host_ctrl #(.STORE_CYC(ST), .RECALL_CYC(RC), .POWERUP_CYC(PU)) nvc_host_ctrl_i (.clock(clock), .rst(rst),
      .reqValid(reqValid), .req(req), .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .opDone(opDone),
      .pins(pins), .byteLinesIn(lineLevel));
   nvc_dev_model nvc_dev_model_i (.clock(clock), .rst(rst), .lowSupply(lowSupply), .pins(pins),
      .lineLevel(lineLevel), .storeCount(storeCount), .recallCount(recallCount), .selCount(selCount),
      .violations(violations));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task tally_and_finish;
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task do_op(input nvc_op_t op, input logic [14:0] a, input logic [7:0] d);
      cyc = 0;
      @(posedge clock);
      req <= '{op: op, addr: a, data: d};
      reqValid <= 1'b1;
      do begin @(negedge clock); cyc++; end while (reqReady !== 1'b1 && cyc < 1000);
      @(posedge clock);
      reqValid <= 1'b0;
      cyc = 0;
      do begin @(negedge clock); cyc++; end while (opDone !== 1'b1 && cyc < 1000);
      check(cyc < 1000, 1);
   endtask : do_op
   task t_powerup;
      @(posedge clock);
      @(negedge clock);
      check({pins.chipSelN, pins.writeN, pins.byteLinesOeN, reqReady}, 4'hE);
      @(posedge clock);
      rst <= 1'b0;
      cyc = 0;
      do begin @(negedge clock); cyc++; end while (reqReady !== 1'b1 && cyc < 1000);
      check(cyc >= PU, 1);
   endtask : t_powerup
   task t_write_read;
      do_op(NVC_OP_WRITE, 15'h1234, 8'h5A);
      do_op(NVC_OP_READ, 15'h1234, 8'h00);
      check({rdValid, rdData}, 9'h15A);
   endtask : t_write_read
   task t_store_recall;
      int sel0;
      do_op(NVC_OP_WRITE, 15'h0100, 8'hA5);
      sel0 = selCount;
      do_op(NVC_OP_STORE, 15'h0000, 8'h00);
      check(storeCount, 1);
      check(selCount - sel0, 6);
      check(cyc >= ST, 1);
      do_op(NVC_OP_WRITE, 15'h0100, 8'h3C);
      do_op(NVC_OP_READ, 15'h0100, 8'h00);
      check(rdData, 8'h3C);
      do_op(NVC_OP_RECALL, 15'h0000, 8'h00);
      check({storeCount[3:0], recallCount[3:0]}, 8'h11);
      check(cyc >= RC, 1);
      do_op(NVC_OP_READ, 15'h0100, 8'h00);
      check(rdData, 8'hA5);
   endtask : t_store_recall
   task t_low_supply;
      int st0;
      st0 = storeCount;
      @(posedge clock);
      lowSupply <= 1'b1;
      do_op(NVC_OP_STORE, 15'h0000, 8'h00);
      check(storeCount - st0, 0);
      @(posedge clock);
      lowSupply <= 1'b0;
   endtask : t_low_supply
   initial
   begin
      repeat (4000) @(posedge clock);
      fails++;
      tally_and_finish();
   end
   initial
   begin
      t_powerup();
      t_write_read();
      t_store_recall();
      t_low_supply();
      check(violations, 0);
      tally_and_finish();
   end
endmodule : tb
